// >>> tpmpc_top.sv
// Top level: reset release, count source, shared counter and eight channels.
`timescale 1ns/1ps
module tpmpc_top
  import tpmpc_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic                        clk_en,
  input  wire tpmpc_pkg::tpmpc_src_t       count_source_select,
  input  wire logic                        fixed_clock_tick,
  input  wire logic                        external_count_clock_in,
  input  wire logic                        center_pwm_select,
  input  wire logic [15:0]                 period_limit_value,
  input  wire logic                        count_reset,
  input  wire logic [15:0]                 channel_match_value [TPMPC_CHANNELS],
  input  wire logic [1:0]                  channel_mode_select [TPMPC_CHANNELS],
  input  wire logic [1:0]                  edge_level_select   [TPMPC_CHANNELS],
  input  wire logic [TPMPC_CHANNELS-1:0]   timer_channel_pin_in,
  input  wire logic [TPMPC_CHANNELS-1:0]   gpio_out,
  input  wire logic [TPMPC_CHANNELS-1:0]   gpio_oe,
  output logic [TPMPC_CHANNELS-1:0]        timer_channel_pin_out,
  output logic [TPMPC_CHANNELS-1:0]        timer_channel_pin_oe,
  output logic [TPMPC_CHANNELS-1:0]        capture_pulse,
  output logic [TPMPC_CHANNELS-1:0]        compare_pulse,
  output logic [15:0]                      captured_value [TPMPC_CHANNELS],
  output logic [15:0]                      timer_count_value,
  output logic                             count_down,
  output logic                             overflow_pulse
);
  logic        rst_meta_reg, rst_sync_reg;
  logic        ext1_reg, ext2_reg, ext3_reg;
  logic        ext1_next, ext2_next, ext3_next;
  logic        tick_reg, tick_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        down_reg, down_next;
  logic        ovf_reg, ovf_next;
  logic        free_run;

  // Reset asserts at once and releases through two flops.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign free_run = (period_limit_value == TPMPC_COUNT_RESET) ||
                    (period_limit_value == TPMPC_COUNT_MAX);

  always_comb
  begin
    ext1_next = external_count_clock_in; // R4
    ext2_next = ext1_reg; // R4
    ext3_next = ext2_reg;
    case (count_source_select) // R3 R18
      TPMPC_SRC_BUS:      tick_next = 1'b1;
      TPMPC_SRC_FIXED:    tick_next = fixed_clock_tick;
      TPMPC_SRC_EXTERNAL: tick_next = ext2_reg && !ext3_reg; // R4
      default:            tick_next = 1'b0;
    endcase
    cnt_next  = cnt_reg;
    down_next = down_reg;
    ovf_next  = 1'b0;
    if (count_reset)
    begin
      cnt_next  = TPMPC_COUNT_RESET;
      down_next = 1'b0;
    end
    else if (tick_reg)
    begin
      if (center_pwm_select && !free_run) // R19
      begin
        if (!down_reg && cnt_reg >= period_limit_value)
        begin
          down_next = 1'b1;
          cnt_next  = cnt_reg - 16'h0001;
        end
        else if (down_reg && cnt_reg == TPMPC_COUNT_RESET)
        begin
          down_next = 1'b0;
          ovf_next  = 1'b1;
          cnt_next  = cnt_reg + 16'h0001;
        end
        else
          cnt_next = down_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
      end
      else if (!free_run && cnt_reg >= period_limit_value) // R20
      begin
        cnt_next  = TPMPC_COUNT_RESET;
        down_next = 1'b0;
        ovf_next  = 1'b1;
      end
      else
      begin
        cnt_next  = cnt_reg + 16'h0001;
        down_next = 1'b0;
        ovf_next  = (cnt_reg == TPMPC_COUNT_MAX);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      ext1_reg <= 1'b0;
      ext2_reg <= 1'b0;
      ext3_reg <= 1'b0;
      tick_reg <= 1'b0;
      cnt_reg  <= TPMPC_COUNT_RESET;
      down_reg <= 1'b0;
      ovf_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      ext1_reg <= ext1_next;
      ext2_reg <= ext2_next;
      ext3_reg <= ext3_next;
      tick_reg <= tick_next;
      cnt_reg  <= cnt_next;
      down_reg <= down_next;
      ovf_reg  <= ovf_next;
    end
  end

  assign timer_count_value = cnt_reg;
  assign count_down        = down_reg;
  assign overflow_pulse    = ovf_reg;

  // Channels beyond those a product needs may be left at edge/level zero.
  for (genvar i = 0; i < TPMPC_CHANNELS; i++) // R2
  begin : g_ch
    tpmpc_channel u_ch
    (
      .clk                 (sys_clk),
      .rst_n               (rst_sync_reg),
      .clk_en              (clk_en),
      .count_tick          (tick_reg),
      .count_source_select (count_source_select),
      .center_pwm_select   (center_pwm_select),
      .count_down          (down_reg),
      .timer_count_value   (cnt_reg),
      .channel_mode_select (channel_mode_select[i]),
      .edge_level_select   (edge_level_select[i]),
      .channel_match_value (channel_match_value[i]),
      .pin_in              (timer_channel_pin_in[i]),
      .gpio_out            (gpio_out[i]),
      .gpio_oe             (gpio_oe[i]),
      .pin_out             (timer_channel_pin_out[i]),
      .pin_oe              (timer_channel_pin_oe[i]),
      .capture_pulse       (capture_pulse[i]),
      .compare_pulse       (compare_pulse[i]),
      .captured_value      (captured_value[i])
    );
  end
endmodule : tpmpc_top

// >>> tpmpc_pkg.sv
// Package of constants and types for the timer channel pin control block.
// Function
// (R1) After reset no channel function is enabled; every pin stays with general I/O.
// (R2) Between one and eight channels, each owning one bidirectional pin.
// (R3) Count source: none, bus rate, fixed crystal clock, or external input.
// (R4) External clock synchronised on bus clock; source at most quarter bus rate.
// (R5) Software avoids channel pin use while that pin is the external clock.
// (R6) With external clock selected, edge/level zero channel still works as software timer.
// (R7) Pin released to general I/O when edge/level zero or count source zero.
// (R8) Center PWM select one with nonzero edge/level drives center-aligned PWM on pin.
// (R9) Without center PWM: mode 00 capture, 01 compare, high bit one edge PWM.
// (R10) Capture makes pin an edge input; edge/level picks which edges capture.
// (R11) Capture input synchronised to bus clock; pulses should span four bus clocks.
// (R12) Compare drives pin; nonzero edge/level toggles, clears or sets on 16-bit match.
// (R13) Toggle compare keeps previous pin level until next match, then inverts.
// (R14) Edge PWM with edge/level 10: high at count zero, low on match.
// (R15) Edge PWM with low edge/level bit set: low at count zero, high on match.
// (R16) Center PWM with edge/level 10: clear on match up, set on match down.
// (R17) Center PWM with low bit set: set on match up, clear on match down.
// (R18) Count source codes: 00 off, 01 bus, 10 fixed clock, 11 external.
// (R19) Center mode counts up to period limit, then down to zero, repeating; with limit 0 or FFFF it only counts up and wraps.
// (R20) Edge PWM period is period limit plus one counts; match value sets duty.
package tpmpc_pkg;
  localparam int          TPMPC_CHANNELS = 8;
  localparam logic [15:0] TPMPC_COUNT_RESET = 16'h0000;
  localparam logic [15:0] TPMPC_COUNT_MAX   = 16'hFFFF;
  localparam logic [1:0]  TPMPC_EL_OFF    = 2'h0;
  localparam logic [1:0]  TPMPC_EL_TOGGLE = 2'h1;
  localparam logic [1:0]  TPMPC_EL_CLEAR  = 2'h2;
  localparam logic [1:0]  TPMPC_EL_SET    = 2'h3;
  localparam logic [1:0]  TPMPC_MODE_CAPTURE = 2'h0;
  localparam logic [1:0]  TPMPC_MODE_COMPARE = 2'h1;

  typedef enum logic [1:0]
  {
    TPMPC_SRC_NONE     = 2'b00,
    TPMPC_SRC_BUS      = 2'b01,
    TPMPC_SRC_FIXED    = 2'b10,
    TPMPC_SRC_EXTERNAL = 2'b11
  } tpmpc_src_t;

  typedef enum logic [2:0]
  {
    TPMPC_FN_IDLE    = 3'b000,
    TPMPC_FN_CAPTURE = 3'b001,
    TPMPC_FN_COMPARE = 3'b010,
    TPMPC_FN_EPWM    = 3'b011,
    TPMPC_FN_CPWM    = 3'b100
  } tpmpc_fn_t;
endpackage : tpmpc_pkg

// >>> tpmpc_channel.sv
// One timer channel: function decode, pin drive, capture edge detect.
`timescale 1ns/1ps
module tpmpc_channel
  import tpmpc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  input  wire logic                    count_tick,
  input  wire tpmpc_pkg::tpmpc_src_t   count_source_select,
  input  wire logic                    center_pwm_select,
  input  wire logic                    count_down,
  input  wire logic [15:0]             timer_count_value,
  input  wire logic [1:0]              channel_mode_select,
  input  wire logic [1:0]              edge_level_select,
  input  wire logic [15:0]             channel_match_value,
  input  wire logic                    pin_in,
  input  wire logic                    gpio_out,
  input  wire logic                    gpio_oe,
  output logic                         pin_out,
  output logic                         pin_oe,
  output logic                         capture_pulse,
  output logic                         compare_pulse,
  output logic [15:0]                  captured_value
);
  tpmpc_fn_t   fn;
  logic        sync1_reg, sync2_reg, sync3_reg;
  logic        sync1_next, sync2_next, sync3_next;
  logic        out_reg, out_next;
  logic        oe_reg, oe_next;
  logic        cap_reg, cap_next;
  logic        cmp_reg, cmp_next;
  logic [15:0] capv_reg, capv_next;
  logic        match, rise, fall, hit;

  always_comb
  begin
    fn = TPMPC_FN_IDLE;
    if (edge_level_select != TPMPC_EL_OFF && count_source_select != TPMPC_SRC_NONE) // R7
    begin
      if (center_pwm_select)
        fn = TPMPC_FN_CPWM; // R8
      else if (channel_mode_select[1])
        fn = TPMPC_FN_EPWM; // R9
      else if (channel_mode_select == TPMPC_MODE_COMPARE)
        fn = TPMPC_FN_COMPARE; // R9
      else
        fn = TPMPC_FN_CAPTURE; // R9
    end
  end

  assign match = count_tick && (timer_count_value == channel_match_value); // R12
  assign rise  = sync2_reg && !sync3_reg;
  assign fall  = !sync2_reg && sync3_reg;

  always_comb
  begin
    sync1_next = pin_in; // R11
    sync2_next = sync1_reg; // R11
    sync3_next = sync2_reg;
    out_next   = out_reg;
    oe_next    = 1'b0;
    cap_next   = 1'b0;
    cmp_next   = 1'b0;
    capv_next  = capv_reg;
    hit        = 1'b0;
    case (edge_level_select) // R10
      TPMPC_EL_TOGGLE: hit = rise;
      TPMPC_EL_CLEAR:  hit = fall;
      TPMPC_EL_SET:    hit = rise || fall;
      default:         hit = 1'b0;
    endcase
    case (fn)
      TPMPC_FN_CAPTURE:
      begin
        out_next = gpio_out;
        if (hit) // R10
        begin
          cap_next  = 1'b1;
          capv_next = timer_count_value;
        end
      end
      TPMPC_FN_COMPARE:
      begin
        oe_next  = 1'b1; // R12
        cmp_next = match;
        if (match)
        begin
          case (edge_level_select)
            TPMPC_EL_TOGGLE: out_next = !out_reg; // R13
            TPMPC_EL_CLEAR:  out_next = 1'b0; // R12
            default:         out_next = 1'b1; // R12
          endcase
        end
      end
      TPMPC_FN_EPWM:
      begin
        oe_next  = 1'b1;
        cmp_next = match;
        if (match)
          out_next = edge_level_select[0]; // R14 R15 R20
        else if (count_tick && timer_count_value == TPMPC_COUNT_RESET)
          out_next = !edge_level_select[0]; // R14 R15
      end
      TPMPC_FN_CPWM:
      begin
        oe_next  = 1'b1;
        cmp_next = match;
        if (match)
          out_next = count_down ? !edge_level_select[0] : edge_level_select[0]; // R16 R17
      end
      default:
      begin
        // General I/O owns the pin; track its level so toggle starts from it.
        oe_next  = gpio_oe; // R1 R6 R7
        out_next = gpio_out;
        // A compare channel with no pin action still reports its match as a software timer.
        if (!center_pwm_select && channel_mode_select == TPMPC_MODE_COMPARE)
          cmp_next = match; // R6
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      cap_reg   <= 1'b0;
      cmp_reg   <= 1'b0;
      capv_reg  <= 16'h0000;
    end
    else if (clk_en)
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      cap_reg   <= cap_next;
      cmp_reg   <= cmp_next;
      capv_reg  <= capv_next;
    end
  end

  assign pin_out        = out_reg;
  assign pin_oe         = oe_reg;
  assign capture_pulse  = cap_reg;
  assign compare_pulse  = cmp_reg;
  assign captured_value = capv_reg;
endmodule : tpmpc_channel

// >>> tpmpc_ext.sv
// Model of the outside circuit on the channel pins and the count clock pin.
`timescale 1ns/1ps
module tpmpc_ext
(
  input  wire logic       sys_clk,
  input  wire logic       ext_run,
  input  wire logic [7:0] drive,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic [7:0]      pin_in,
  output logic            ext_clk
);
  logic [1:0] div_reg = 2'h0;
  logic       clk_reg = 1'h0;
  // A pin shows the device's level while it drives, else the level driven here.
  assign pin_in  = (pin_oe & pin_out) | (~pin_oe & drive);
  assign ext_clk = clk_reg;
  // Eight bus clocks a period, half the fastest legal rate; low when stopped.
  always @(posedge sys_clk)
  begin
    div_reg <= ext_run ? div_reg + 2'h1 : 2'h0;
    clk_reg <= ext_run ? clk_reg ^ (div_reg == 2'h3) : 1'h0;
  end
endmodule : tpmpc_ext

// >>> tpmpc_top_sva.sv
// Assertions on the ports of the timer channel pin control top.
`timescale 1ns/1ps
module tpmpc_chk
  import tpmpc_pkg::*;
(
  input wire logic                      sys_clk,
  input wire logic                      reset_n,
  input wire logic                      clk_en,
  input wire tpmpc_pkg::tpmpc_src_t     count_source_select,
  input wire logic                      center_pwm_select,
  input wire logic [15:0]               period_limit_value,
  input wire logic                      count_reset,
  input wire logic [1:0]                channel_mode_select [TPMPC_CHANNELS],
  input wire logic [1:0]                edge_level_select [TPMPC_CHANNELS],
  input wire logic [TPMPC_CHANNELS-1:0] gpio_out,
  input wire logic [TPMPC_CHANNELS-1:0] gpio_oe,
  input wire logic [TPMPC_CHANNELS-1:0] timer_channel_pin_out,
  input wire logic [TPMPC_CHANNELS-1:0] timer_channel_pin_oe,
  input wire logic [TPMPC_CHANNELS-1:0] compare_pulse,
  input wire logic [15:0]               timer_count_value,
  input wire logic                      count_down
);
  logic [2:0] live_reg;
  logic       run;
  logic       busy0;
  // Outputs are held low for two edges after release, so checks wait three.
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      live_reg <= 3'h0;
    else
      live_reg <= {live_reg[1:0], 1'h1};
  assign run   = live_reg[2] && clk_en;
  assign busy0 = count_source_select != TPMPC_SRC_NONE &&
                 edge_level_select[0] != TPMPC_EL_OFF && !center_pwm_select;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_edge;
    (run && count_source_select == TPMPC_SRC_BUS && !center_pwm_select &&
     !count_reset && !count_down)[*2];
  endsequence
  AST_IDLE_GPIO: assert property (
    run && (edge_level_select[0] == TPMPC_EL_OFF || count_source_select == TPMPC_SRC_NONE)
    |=> timer_channel_pin_oe[0] == $past(gpio_oe[0]) &&
    timer_channel_pin_out[0] == $past(gpio_out[0])) else $error("Idle pin left general I/O.");
  AST_CAPTURE_IN: assert property (
    run && busy0 && channel_mode_select[0] == TPMPC_MODE_CAPTURE
    |=> !timer_channel_pin_oe[0]) else $error("Capture pin is driven.");
  AST_COMPARE_OUT: assert property (
    run && busy0 && channel_mode_select[0] == TPMPC_MODE_COMPARE
    |=> timer_channel_pin_oe[0]) else $error("Compare pin not driven.");
  AST_CPWM_OUT: assert property (
    run && center_pwm_select && count_source_select != TPMPC_SRC_NONE &&
    edge_level_select[1] != TPMPC_EL_OFF |=> timer_channel_pin_oe[1])
    else $error("Center PWM pin not driven.");
  AST_STOPPED: assert property (
    (count_source_select == TPMPC_SRC_NONE && !count_reset)[*2] |=> $stable(timer_count_value))
    else $error("Counter moved with no source.");
  AST_BUS_STEP: assert property (
    s_edge ##0 timer_count_value < period_limit_value
    |=> timer_count_value == $past(timer_count_value) + 16'h1) else $error("Bus count step.");
  AST_WRAP: assert property (
    s_edge ##0 timer_count_value == period_limit_value && period_limit_value != 16'h0
    |=> timer_count_value == 16'h0) else $error("Counter did not wrap at limit.");
  AST_CPWM_TURN: assert property (
    (run && count_source_select == TPMPC_SRC_BUS && center_pwm_select && !count_reset)[*2]
    ##0 timer_count_value == period_limit_value && !count_down &&
    period_limit_value != 16'h0 && period_limit_value != 16'hFFFF
    |=> count_down && timer_count_value == $past(period_limit_value) - 16'h1)
    else $error("Center count did not turn.");
  AST_EPWM_LEVEL: assert property (
    compare_pulse[0] && busy0 && channel_mode_select[0][1]
    |-> timer_channel_pin_out[0] == edge_level_select[0][0]) else $error("Edge PWM level.");
  AST_CPWM_LEVEL: assert property (
    compare_pulse[1] && center_pwm_select && edge_level_select[1] != TPMPC_EL_OFF
    |-> timer_channel_pin_out[1] == (edge_level_select[1][0] ^ $past(count_down)))
    else $error("Center PWM level.");
  cover property (compare_pulse[1] && center_pwm_select);
  cover property ($rose(count_down));
  cover property (compare_pulse[0] && channel_mode_select[0] == TPMPC_MODE_COMPARE);
endmodule : tpmpc_chk
bind tpmpc_top tpmpc_chk u_tpmpc_chk (.*);

// >>> timer_channel_pin_control_tb_top.sv
// Self-checking bench for the timer channel pin control block.
`timescale 1ns/1ps
module timer_channel_pin_control_tb_top;
  import tpmpc_pkg::*;
  localparam int N = TPMPC_CHANNELS;
  typedef struct packed {logic [1:0] mode; logic [1:0] el; tpmpc_src_t src; logic g; logic oe;} tpmpc_row_t;
  localparam tpmpc_row_t ROWS [6] = '{'{2'h1, 2'h0, TPMPC_SRC_BUS, 1'h1, 1'h1},
    '{2'h1, 2'h1, TPMPC_SRC_NONE, 1'h1, 1'h1}, '{2'h0, 2'h1, TPMPC_SRC_BUS, 1'h1, 1'h0},
    '{2'h1, 2'h2, TPMPC_SRC_BUS, 1'h0, 1'h1}, '{2'h2, 2'h2, TPMPC_SRC_BUS, 1'h0, 1'h1},
    '{2'h3, 2'h1, TPMPC_SRC_FIXED, 1'h0, 1'h1}};
  localparam tpmpc_src_t SRCS [5] = '{TPMPC_SRC_BUS, TPMPC_SRC_NONE, TPMPC_SRC_BUS,
    TPMPC_SRC_FIXED, TPMPC_SRC_EXTERNAL};
  localparam logic [15:0] RATES [5] = '{16'h0, 16'h0, 16'h50, 16'h28, 16'hA};
  localparam logic [1:0] ELS [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
  logic              sys_clk = 1'h0;
  logic              reset_n = 1'h0;
  logic              clk_en = 1'h1;
  tpmpc_src_t        count_source_select = TPMPC_SRC_NONE;
  logic              fixed_clock_tick = 1'h0;
  logic              external_count_clock_in;
  logic              center_pwm_select = 1'h0;
  logic [15:0]       period_limit_value = 16'h0008;
  logic              count_reset = 1'h0;
  logic [15:0]       channel_match_value [N] = '{default: 16'h0005};
  logic [1:0]        channel_mode_select [N] = '{default: 2'h0};
  logic [1:0]        edge_level_select [N] = '{default: 2'h0};
  logic [N-1:0]      timer_channel_pin_in;
  logic [N-1:0]      gpio_out = 8'h00;
  logic [N-1:0]      gpio_oe = 8'hA5;
  logic [N-1:0]      drive = 8'h00;
  logic              ext_run = 1'h0;
  logic [N-1:0]      timer_channel_pin_out;
  logic [N-1:0]      timer_channel_pin_oe;
  logic [N-1:0]      capture_pulse;
  logic [N-1:0]      compare_pulse;
  logic [15:0]       captured_value [N];
  logic [15:0]       timer_count_value;
  logic              count_down;
  logic              overflow_pulse;
  logic [15:0]       c0;
  int                err_count = 0;
  int                checks = 0;
  int                n;
  tpmpc_top u_tpmpc_top (.*);
  tpmpc_ext u_tpmpc_ext (.sys_clk(sys_clk), .ext_run(ext_run), .drive(drive),
    .pin_out(timer_channel_pin_out), .pin_oe(timer_channel_pin_oe),
    .pin_in(timer_channel_pin_in), .ext_clk(external_count_clock_in));
  always #50 sys_clk = ~sys_clk;
  always @(negedge sys_clk) fixed_clock_tick <= ~fixed_clock_tick;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc
  task automatic restart;
    count_reset = 1'h1;
    cyc(1);
    count_reset = 1'h0;
  endtask : restart
  task automatic waitp(input int ch);
    int k;
    k = 0;
    while (compare_pulse[ch] !== 1'h1 && k < 200)
    begin
      cyc(1);
      k++;
    end
    chk("match seen", k < 200, 16'h1);
    cyc(1);
  endtask : waitp
  task automatic pwm(input int ch, input int per, input int hi);
    int k;
    int h;
    k = 0;
    h = 0;
    // Wait for the next period to start first, so no level left by the old polarity is counted.
    cyc(1);
    while (overflow_pulse !== 1'h1 && k < 40)
    begin
      cyc(1);
      k++;
    end
    repeat (per)
    begin
      cyc(1);
      h += (timer_channel_pin_out[ch] === 1'h1);
    end
    chk("period end", overflow_pulse, 16'h1);
    chk("high time", h, hi);
  endtask : pwm
  task automatic caps(output int k);
    k = 0;
    repeat (8)
    begin
      c0 = timer_count_value;
      cyc(1);
      k += (capture_pulse[0] === 1'h1);
      if (capture_pulse[0] === 1'h1)
        chk("captured count", captured_value[0], c0);
    end
  endtask : caps
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    report_and_stop();
  end
  initial
  begin
    cyc(5);
    chk("oe in reset", timer_channel_pin_oe, 16'h0);
    cyc(5);
    reset_n = 1'h1;
    cyc(4);
    chk("oe after reset", timer_channel_pin_oe, 16'hA5);
    gpio_oe = 8'h00;
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      channel_mode_select[0] = ROWS[i].mode;
      edge_level_select[0] = ROWS[i].el;
      count_source_select = ROWS[i].src;
      gpio_oe[0] = ROWS[i].g;
      cyc(3);
      chk("pin owner", timer_channel_pin_oe[0], ROWS[i].oe);
    end
    $display("table test done");
    ext_run = 1'h1;
    period_limit_value = 16'hFFFF;
    for (int i = 0; i < 5; i++)
    begin
      count_source_select = SRCS[i];
      clk_en = (i != 0);
      cyc(8);
      c0 = timer_count_value;
      cyc(80);
      chk("count rate", timer_count_value - c0, RATES[i]);
    end
    // The external clock stays selected so channel one acts as a bare timer.
    period_limit_value = 16'h0008;
    channel_mode_select[1] = TPMPC_MODE_COMPARE;
    restart();
    waitp(1);
    chk("timer pin free", timer_channel_pin_oe[1], 16'h0);
    $display("source test done");
    count_source_select = TPMPC_SRC_BUS;
    channel_mode_select[0] = 2'h2;
    for (int e = 2; e > 0; e--)
    begin
      edge_level_select[0] = 2'(e);
      pwm(0, 9, e == 2 ? 5 : 4);
    end
    center_pwm_select = 1'h1;
    restart();
    for (int e = 2; e > 0; e--)
    begin
      edge_level_select[1] = 2'(e);
      pwm(1, 16, e == 2 ? 10 : 6);
    end
    chk("center owners", {timer_channel_pin_oe[2], timer_channel_pin_oe[1]}, 16'h1);
    $display("pwm test done");
    center_pwm_select = 1'h0;
    channel_mode_select[0] = TPMPC_MODE_COMPARE;
    edge_level_select[0] = TPMPC_EL_OFF;
    channel_match_value[0] = 16'h0003;
    gpio_out[0] = 1'h1;
    gpio_oe[0] = 1'h1;
    cyc(3);
    edge_level_select[0] = TPMPC_EL_TOGGLE;
    restart();
    chk("toggle start", timer_channel_pin_out[0], 16'h1);
    for (int i = 0; i < 4; i++)
    begin
      edge_level_select[0] = ELS[i];
      waitp(0);
      chk("compare pin", timer_channel_pin_out[0], 16'(i & 1));
    end
    $display("compare test done");
    channel_mode_select[0] = TPMPC_MODE_CAPTURE;
    edge_level_select[0] = 2'h1;
    cyc(8);
    // Each level is held eight bus clocks, above the narrowest reliable pulse.
    for (int e = 1; e < 4; e++)
    begin
      edge_level_select[0] = 2'(e);
      drive[0] = 1'h1;
      caps(n);
      chk("rise capture", n, 16'(e & 1));
      drive[0] = 1'h0;
      caps(n);
      chk("fall capture", n, 16'(e >> 1));
    end
    $display("capture test done");
    report_and_stop();
  end
endmodule : timer_channel_pin_control_tb_top
